// ---- include/wwdc_pkg.sv ----
// Constants, carriers and state types of the watchdog clear logic
package wwdc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL_A = 8'h00;
   localparam logic [7:0] OFS_CONTROL_B = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_TIMER = 8'h10;
   localparam logic [7:0] OFS_POWER = 8'h14;

   ////////////////////////////////////////////////////////////////////////
   // Field positions and widths
   localparam int SW_ENABLE_POS = 0;
   localparam int TIMER_W = 10;
   localparam int WIN_MSB_W = 5;
   localparam int EVT_W = 3;
   localparam int EVT_SLEEP_TIMEOUT = 0;
   localparam int EVT_WINDOW_VIOL = 1;
   localparam int EVT_RESET_TIMEOUT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Configuration encodings
   localparam logic [1:0] ENABLE_OFF = 2'h0;
   localparam logic [1:0] ENABLE_SW = 2'h1;
   localparam logic [1:0] ENABLE_AWAKE = 2'h2;
   localparam logic [1:0] ENABLE_ALWAYS = 2'h3;
   localparam logic [2:0] WINDOW_SW_SELECT = 3'h7;
   localparam logic [2:0] WINDOW_FULL = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and counts
   localparam logic [2:0] SW_WINDOW_RESET = 3'h7;
   localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
   localparam int PRESCALE_CYCLES = 32;
   localparam logic [4:0] PRESCALE_MAX = 5'(PRESCALE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   // Active-low status flags, all high after power-on
   typedef struct packed {
      logic window_violation_flag;
      logic watchdog_reset_cause;
      logic powerdown_flag;
      logic timeout_flag;
   } wwdc_flags_t;
   localparam wwdc_flags_t FLAGS_RESET = 4'hf;

   typedef enum logic [1:0] {
      PH_AWAKE = 2'b00,
      PH_SLEEP = 2'b01,
      PH_STARTUP = 2'b11
   } wwdc_phase_t;

   typedef struct packed {
      wwdc_phase_t phase;
      logic armed;
      logic sleep_d;
      logic sw_enable;
      logic [2:0] sw_window;
      wwdc_flags_t flags;
      logic [EVT_W-1:0] status;
      logic [EVT_W-1:0] mask;
      logic reset_req;
      logic wake_req;
      logic [31:0] prdata;
      logic pslverr;
   } wwdc_state_t;

   typedef struct packed {
      logic [4:0] prescale;
      logic [TIMER_W-1:0] timer;
      logic timeout;
   } wwdc_cnt_state_t;

endpackage

// ---- rtl/wwdc_counter.sv ----
// Prescaler and watchdog timer with synchronous clear and time-out pulse
module wwdc_counter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic clear,
   input wire logic run,
   // Results
   output logic [wwdc_pkg::TIMER_W-1:0] timer,
   output logic timeout
);
   wwdc_pkg::wwdc_cnt_state_t state;
   wwdc_pkg::wwdc_cnt_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.timeout = 1'b0;
      if (clear) begin
         // Prescaler too, so a clear always restarts a full period
         next_state.prescale = '0;
         next_state.timer = '0;
      end else if (run) begin
         if (state.prescale == wwdc_pkg::PRESCALE_MAX) begin
            next_state.prescale = '0;
            next_state.timer = state.timer + 1'b1;
            if (&state.timer) begin
               next_state.timeout = 1'b1;
            end
         end else begin
            next_state.prescale = state.prescale + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign timer = state.timer;
   assign timeout = state.timeout;
endmodule

// ---- rtl/wwdc_window.sv ----
// Window open decision from the timer's top bits
module wwdc_window (
   // Timer top bits and window setting
   input wire logic [wwdc_pkg::WIN_MSB_W-1:0] timer_msb,
   input wire logic [2:0] window,
   // Result
   output logic window_open
);
   logic [wwdc_pkg::WIN_MSB_W-1:0] threshold;

   // Setting n leaves (n+1)/8 of the period open at its end
   always_comb begin
      threshold = {(3'h7 - window), 2'b00};
      window_open = (timer_msb >= threshold);
   end
endmodule

// ---- rtl/wwdc_top.sv ----
// Windowed watchdog clearing, arming and Sleep logic with APB registers
//
// The register offsets and the APB interface to the registers were left to the implementer.

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Count cleared on reset, on Sleep entry and while disabled.
// - A valid clear-watchdog instruction clears the count.
// - Waking from Sleep by interrupt clears the count.
// - Held clear while start-up timer runs, also after Sleep exit.
// - Any write to either control register clears the count.
// - Windowed mode: clear instruction works only after arming read.
// - Windowed mode: unarmed clear instruction is a window violation.
// - Enabled in Sleep, counting resumes from zero after entry.
// - Every Sleep exit clears the count once more.
// - Time-out in Sleep wakes the device instead of resetting it.
// - Time-out in Sleep updates time-out and power-down flags.
// - Held clear when enable config is 00, or 01 with enable bit 0.
// - Clear instruction in closed window is a violation causing reset.
// - Window state compares timer's five top bits with setting.
// - Window comes from config unless selector is 111, then software.
// - Violation clears violation flag; power-on or firmware sets it.
module wwdc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor and system events
   input wire logic clear_watchdog_instr,
   input wire logic sleep_state,
   input wire logic wake_by_interrupt,
   input wire logic oscillator_startup_timer,
   // Configuration
   input wire logic [1:0] watchdog_enable_cfg,
   input wire logic [2:0] window_cfg_select,
   // Reactions
   output logic device_reset_req,
   output logic sleep_wake_req,
   output wwdc_pkg::wwdc_flags_t power_flags,
   output logic irq
);
   wwdc_pkg::wwdc_state_t state;
   wwdc_pkg::wwdc_state_t next_state;

   logic [wwdc_pkg::TIMER_W-1:0] timer;
   logic timeout;
   logic window_open;
   logic [2:0] window;
   logic windowed;
   logic enabled;
   logic sleep_entry;
   logic sleep_exit;
   logic wr_access;
   logic rd_access;
   logic setup;
   logic ctl_write;
   logic violation;
   logic valid_clear;
   logic clear;
   logic [wwdc_pkg::EVT_W-1:0] events;

   //////////////////////////////////////////////////////////////////////////
   // Sub-blocks
   wwdc_counter u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear),
      .run(enabled),
      .timer(timer),
      .timeout(timeout)
   );

   wwdc_window u_window (
      .timer_msb(
         timer[wwdc_pkg::TIMER_W-1 -: wwdc_pkg::WIN_MSB_W]),
      .window(window),
      .window_open(window_open)
   );

   //////////////////////////////////////////////////////////////////////////
   // Decode of events and conditions
   always_comb begin
      setup = psel & ~penable;
      wr_access = psel & penable & pwrite;
      rd_access = psel & penable & ~pwrite;
      ctl_write = wr_access &
         ((paddr == wwdc_pkg::OFS_CONTROL_A) |
          (paddr == wwdc_pkg::OFS_CONTROL_B));

      // Software window only when the selector asks for it
      if (window_cfg_select == wwdc_pkg::WINDOW_SW_SELECT) begin
         window = state.sw_window;
      end else begin
         window = window_cfg_select;
      end
      windowed = (window != wwdc_pkg::WINDOW_FULL);

      case (watchdog_enable_cfg)
         wwdc_pkg::ENABLE_OFF: enabled = 1'b0;
         wwdc_pkg::ENABLE_SW: enabled = state.sw_enable;
         wwdc_pkg::ENABLE_AWAKE: enabled = ~sleep_state;
         default: enabled = 1'b1;
      endcase

      sleep_entry = sleep_state & ~state.sleep_d;
      sleep_exit = ~sleep_state & state.sleep_d;

      // Unarmed or early clear in windowed mode is a violation
      violation = clear_watchdog_instr & enabled & windowed &
         (~state.armed | ~window_open);
      valid_clear = clear_watchdog_instr & ~violation;

      clear = ~enabled
         | sleep_entry
         | sleep_exit | wake_by_interrupt
         | oscillator_startup_timer
         | ctl_write
         | valid_clear;

      events = '0;
      events[wwdc_pkg::EVT_SLEEP_TIMEOUT] = timeout & sleep_state;
      events[wwdc_pkg::EVT_WINDOW_VIOL] = violation;
      events[wwdc_pkg::EVT_RESET_TIMEOUT] = timeout & ~sleep_state;
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;
      next_state.sleep_d = sleep_state;
      next_state.reset_req = 1'b0;
      next_state.wake_req = 1'b0;

      // Sleep phase tracking
      case (state.phase)
         wwdc_pkg::PH_AWAKE: begin
            if (sleep_state) begin
               next_state.phase = wwdc_pkg::PH_SLEEP;
            end
         end
         wwdc_pkg::PH_SLEEP: begin
            if (!sleep_state) begin
               if (oscillator_startup_timer) begin
                  next_state.phase = wwdc_pkg::PH_STARTUP;
               end else begin
                  next_state.phase = wwdc_pkg::PH_AWAKE;
               end
            end
         end
         wwdc_pkg::PH_STARTUP: begin
            if (!oscillator_startup_timer) begin
               next_state.phase = wwdc_pkg::PH_AWAKE;
            end
         end
         default: next_state.phase = wwdc_pkg::PH_AWAKE;
      endcase

      // Register writes
      if (wr_access) begin
         case (paddr)
            wwdc_pkg::OFS_CONTROL_A:
               next_state.sw_enable = pwdata[wwdc_pkg::SW_ENABLE_POS];
            wwdc_pkg::OFS_CONTROL_B:
               next_state.sw_window = pwdata[2:0];
            wwdc_pkg::OFS_STATUS:
               next_state.status = state.status &
                  ~pwdata[wwdc_pkg::EVT_W-1:0];
            wwdc_pkg::OFS_MASK:
               next_state.mask = pwdata[wwdc_pkg::EVT_W-1:0];
            wwdc_pkg::OFS_POWER: begin
               // Firmware may only set the active-low flags
               next_state.flags = state.flags | pwdata[3:0];
            end
            default: ;
         endcase
      end

      // Arming read; any clear drops the armed state
      if (clear || violation) begin
         next_state.armed = 1'b0;
      end else if (rd_access && paddr == wwdc_pkg::OFS_CONTROL_A) begin
         next_state.armed = 1'b1;
      end

      // Sticky events, set wins over the clearing write
      next_state.status = next_state.status | events;

      // Hardware flag updates take priority over firmware writes
      if (sleep_entry) begin
         next_state.flags.powerdown_flag = 1'b0;
      end
      if (events[wwdc_pkg::EVT_SLEEP_TIMEOUT]) begin
         next_state.wake_req = 1'b1;
         next_state.flags.timeout_flag = 1'b0;
         next_state.flags.powerdown_flag = 1'b0;
      end
      if (events[wwdc_pkg::EVT_RESET_TIMEOUT]) begin
         next_state.reset_req = 1'b1;
         next_state.flags.timeout_flag = 1'b0;
         next_state.flags.watchdog_reset_cause = 1'b0;
      end
      if (violation) begin
         next_state.reset_req = 1'b1;
         next_state.flags.window_violation_flag = 1'b0;
         next_state.flags.watchdog_reset_cause = 1'b0;
      end

      // Read data captured in the setup cycle
      if (setup) begin
         next_state.prdata = '0;
         next_state.pslverr = 1'b0;
         case (paddr)
            wwdc_pkg::OFS_CONTROL_A:
               next_state.prdata[wwdc_pkg::SW_ENABLE_POS] = state.sw_enable;
            wwdc_pkg::OFS_CONTROL_B:
               next_state.prdata[2:0] = state.sw_window;
            wwdc_pkg::OFS_STATUS:
               next_state.prdata[wwdc_pkg::EVT_W-1:0] = state.status;
            wwdc_pkg::OFS_MASK:
               next_state.prdata[wwdc_pkg::EVT_W-1:0] = state.mask;
            wwdc_pkg::OFS_TIMER:
               next_state.prdata[wwdc_pkg::TIMER_W-1:0] = timer;
            wwdc_pkg::OFS_POWER:
               next_state.prdata[3:0] = state.flags;
            default: next_state.pslverr = 1'b1;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.phase <= wwdc_pkg::PH_AWAKE;
         state.armed <= 1'b0;
         state.sleep_d <= 1'b0;
         state.sw_enable <= 1'b0;
         state.sw_window <= wwdc_pkg::SW_WINDOW_RESET;
         state.flags <= wwdc_pkg::FLAGS_RESET;
         state.status <= '0;
         state.mask <= wwdc_pkg::MASK_RESET;
         state.reset_req <= 1'b0;
         state.wake_req <= 1'b0;
         state.prdata <= '0;
         state.pslverr <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = state.prdata;
   // Zero wait states: data was captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = state.pslverr;
   assign device_reset_req = state.reset_req;
   assign sleep_wake_req = state.wake_req;
   assign power_flags = state.flags;
   assign irq = |(state.status & state.mask);
endmodule

// ---- testbench/wwdc_chk.sv ----
// Port-level assertions of the windowed watchdog clear logic
module wwdc_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   // Processor events and configuration
   input wire logic clear_watchdog_instr,
   input wire logic sleep_state,
   input wire logic [1:0] watchdog_enable_cfg,
   // Reactions
   input wire logic device_reset_req,
   input wire logic sleep_wake_req,
   input wire wwdc_pkg::wwdc_flags_t power_flags,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_reset_pulse: assert property (
      device_reset_req |=> !device_reset_req)
      else $error("reset request wider than one cycle");
   a_reset_cause: assert property (
      device_reset_req |-> !power_flags.watchdog_reset_cause)
      else $error("reset request without reset cause");
   a_wake_pulse: assert property (
      sleep_wake_req |=> !sleep_wake_req)
      else $error("wake request wider than one cycle");
   a_sleep_no_reset: assert property (
      sleep_wake_req |-> !device_reset_req && $past(sleep_state))
      else $error("wake request outside sleep or with reset");
   a_wake_flags: assert property (
      sleep_wake_req |->
      !power_flags.timeout_flag && !power_flags.powerdown_flag)
      else $error("sleep time-out flags not recorded");
   a_violation_flag: assert property (
      clear_watchdog_instr ##1 device_reset_req |->
      !power_flags.window_violation_flag)
      else $error("violation without violation flag");
   a_off_quiet: assert property (
      (watchdog_enable_cfg == wwdc_pkg::ENABLE_OFF) [*3] |->
      !device_reset_req && !sleep_wake_req)
      else $error("reaction while watchdog disabled");
   a_flag_set_write: assert property (
      |(power_flags & ~$past(power_flags)) |->
      $past(psel && penable && pwrite && paddr == wwdc_pkg::OFS_POWER))
      else $error("power flag set without firmware write");

   c_reset: cover property (device_reset_req);
   c_wake: cover property (sleep_wake_req);
   c_irq: cover property (irq);
endmodule

bind wwdc_top wwdc_chk u_wwdc_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .clear_watchdog_instr(clear_watchdog_instr), .sleep_state(sleep_state),
   .watchdog_enable_cfg(watchdog_enable_cfg),
   .device_reset_req(device_reset_req), .sleep_wake_req(sleep_wake_req),
   .power_flags(power_flags), .irq(irq));

// ---- testbench/wwdc_cpu_model.sv ----
// Processor core model: clear instruction, Sleep entry and wake-up
module wwdc_cpu_model (
   // Clock
   input wire logic pclk,
   // Core events
   output logic clear_watchdog_instr,
   output logic sleep_state,
   output logic wake_by_interrupt,
   output logic oscillator_startup_timer
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      clear_watchdog_instr = 1'b0;
      sleep_state = 1'b0;
      wake_by_interrupt = 1'b0;
      oscillator_startup_timer = 1'b0;
   end
   task automatic clear_instr();
      @(posedge pclk);
      clear_watchdog_instr <= 1'b1;
      @(posedge pclk);
      clear_watchdog_instr <= 1'b0;
   endtask
   task automatic enter_sleep();
      @(posedge pclk);
      sleep_state <= 1'b1;
   endtask
   // Start-up timer stays high until startup_done, so the bench can look in
   task automatic leave_sleep(input logic by_irq, input logic startup);
      @(posedge pclk);
      sleep_state <= 1'b0;
      wake_by_interrupt <= by_irq;
      oscillator_startup_timer <= startup;
      @(posedge pclk);
      wake_by_interrupt <= 1'b0;
   endtask
   task automatic startup_done();
      @(posedge pclk);
      oscillator_startup_timer <= 1'b0;
   endtask
endmodule

// ---- testbench/windowed_watchdog_clear_logic_test.sv ----
// Self-checking testbench of the windowed watchdog clear logic
module windowed_watchdog_clear_logic_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, t;
   logic device_reset_req, sleep_wake_req, irq, clr, slp, wki, startup;
   logic [1:0] en_cfg;
   logic [2:0] win_cfg;
   wwdc_pkg::wwdc_flags_t power_flags;
   int err_total = 0, n_checks = 0, n_rst = 0, n_wake = 0, rst0, w0;

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (device_reset_req === 1'b1) n_rst++;
      if (sleep_wake_req === 1'b1) n_wake++;
   end

   wwdc_top u_wwdc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clear_watchdog_instr(clr), .sleep_state(slp),
      .wake_by_interrupt(wki), .oscillator_startup_timer(startup),
      .watchdog_enable_cfg(en_cfg), .window_cfg_select(win_cfg),
      .device_reset_req(device_reset_req), .sleep_wake_req(sleep_wake_req),
      .power_flags(power_flags), .irq(irq));
   wwdc_cpu_model u_wwdc_cpu_model (.pclk(pclk), .clear_watchdog_instr(clr),
      .sleep_state(slp), .wake_by_interrupt(wki),
      .oscillator_startup_timer(startup));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] flags_exp(input logic v, c, p, o);
      return {28'h0, v, c, p, o};
   endfunction
   function automatic logic win_open(input logic [9:0] tm,
         input logic [2:0] w);
      return tm[9:5] >= 5'((7 - w) * 4);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr_en, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit of its own: only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Violation count seen after one clear instruction
   task automatic clear_and_count(input logic [31:0] exp);
      rst0 = n_rst;
      u_wwdc_cpu_model.clear_instr();
      idle(3);
      chk(n_rst - rst0, exp);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge pclk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      en_cfg = wwdc_pkg::ENABLE_ALWAYS;
      win_cfg = wwdc_pkg::WINDOW_SW_SELECT;
      void'($urandom(32'hd3b4));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(wwdc_pkg::OFS_POWER);
      chk(r, 32'hf);
      rd(wwdc_pkg::OFS_CONTROL_B);
      chk(r, 32'h7);
      rd(8'h3c);
      chk(e, 1);
      chk(r, 32'h0);
      chk(pready, 1);
      idle(64 + $urandom % 200);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r != 0, 1);
      // Upper bits random, software window 6
      wr(wwdc_pkg::OFS_CONTROL_B, ($urandom & 32'hffff_fff8) | 32'h6);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      rd(wwdc_pkg::OFS_CONTROL_B);
      chk(r, 32'h6);
      clear_and_count(1);
      rd(wwdc_pkg::OFS_POWER);
      chk(r, flags_exp(0, 0, 1, 1));
      wr(wwdc_pkg::OFS_POWER, 32'hf);
      rd(wwdc_pkg::OFS_POWER);
      chk(r, 32'hf);
      // Armed, then wait until the window opens
      wr(wwdc_pkg::OFS_CONTROL_B, 32'h6);
      rd(wwdc_pkg::OFS_CONTROL_A);
      idle(4200);
      rd(wwdc_pkg::OFS_TIMER);
      t = r;
      clear_and_count(!win_open(t[9:0], 3'h6));
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      // Window open again, but the valid clear dropped the arming
      idle(4200);
      clear_and_count(1);
      // Config window, armed but still closed
      win_cfg <= 3'h6;
      wr(wwdc_pkg::OFS_CONTROL_B, 32'h7);
      rd(wwdc_pkg::OFS_CONTROL_A);
      clear_and_count(!win_open(10'h0, 3'h6));
      rd(wwdc_pkg::OFS_STATUS);
      chk(irq, 0);
      chk(r, 32'h2);
      wr(wwdc_pkg::OFS_MASK, 32'h2);
      idle(1);
      chk(irq, 1);
      wr(wwdc_pkg::OFS_STATUS, 32'h2);
      idle(1);
      chk(irq, 0);
      win_cfg <= wwdc_pkg::WINDOW_SW_SELECT;
      for (int i = 0; i < 2; i++) begin
         en_cfg <= 2'(i);
         idle(100);
         rd(wwdc_pkg::OFS_TIMER);
         chk(r, 0);
      end
      wr(wwdc_pkg::OFS_CONTROL_A, 32'h1);
      idle(100);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r != 0, 1);
      // Sleep with a time-out
      en_cfg <= wwdc_pkg::ENABLE_ALWAYS;
      // Earlier violations left flags low; start the Sleep part clean
      wr(wwdc_pkg::OFS_POWER, 32'hf);
      u_wwdc_cpu_model.enter_sleep();
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      idle(100);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r != 0, 1);
      rst0 = n_rst;
      w0 = n_wake;
      for (int i = 0; i < 40000 && n_wake == w0; i++) @(posedge pclk);
      chk(n_wake - w0, 1);
      chk(n_rst - rst0, 0);
      rd(wwdc_pkg::OFS_POWER);
      chk(r, flags_exp(1, 1, 0, 0));
      u_wwdc_cpu_model.leave_sleep(1'b0, 1'b1);
      idle(100);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      u_wwdc_cpu_model.startup_done();
      idle(100);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r != 0, 1);
      u_wwdc_cpu_model.enter_sleep();
      idle(100);
      u_wwdc_cpu_model.leave_sleep(1'b1, 1'b0);
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      // Time-out while awake
      rst0 = n_rst;
      w0 = n_wake;
      for (int i = 0; i < 40000 && n_rst == rst0; i++) @(posedge pclk);
      chk(n_rst - rst0, 1);
      chk(n_wake - w0, 0);
      rd(wwdc_pkg::OFS_STATUS);
      chk(r, 32'h5);
      rd(wwdc_pkg::OFS_POWER);
      chk(r, flags_exp(1, 0, 0, 0));
      // Second reset in mid-run
      presetn <= 1'b0;
      idle(2);
      presetn <= 1'b1;
      rd(wwdc_pkg::OFS_TIMER);
      chk(r, 0);
      rd(wwdc_pkg::OFS_MASK);
      chk(r, 32'h0);
      rd(wwdc_pkg::OFS_POWER);
      chk(r, 32'hf);
      tally_and_finish();
   end
endmodule
